// ===== logic/lin_break_map.svh
// Register map, field positions, reset values and timing counts for the
// LIN break field controller. Included by the design, the checker and the bench.
//
// Notes on behaviour
// - Reception flag high during break reception
// - Reception error keeps flag, restarts detection
// - Receive trigger arms detection, reads zero
// - Transmit trigger starts break, reads zero
// - Length field selects 13 to 20 bits
// - Option register index 3, resets to 14h
// - Transmit inversion bit inverts transmit pin
// - Receive inversion bit inverts sampled input
// - Receive enable gates reception
`ifndef LIN_BREAK_MAP_SVH
`define LIN_BREAK_MAP_SVH

// Register indexes; byte address is four times the index
`define LBF_IDX_CONTROL 6'h00
`define LBF_IDX_OPTION 6'h03
`define LBF_IDX_STATUS 6'h04
`define LBF_IDX_IRQ_STATUS 6'h05
`define LBF_IDX_IRQ_MASK 6'h06

// Option register fields
`define LBF_OPT_RX_FLAG 7
`define LBF_OPT_RX_TRIG 6
`define LBF_OPT_TX_TRIG 5
`define LBF_OPT_SEL_HI 4
`define LBF_OPT_SEL_LO 2
`define LBF_OPT_TX_INV 1
`define LBF_OPT_RX_INV 0
`define LBF_OPT_RESET 8'h14

// Control register fields
`define LBF_CTL_POWER 7
`define LBF_CTL_TXE 6
`define LBF_CTL_RXE 5
`define LBF_CTL_RESET 8'h00

// Status register field
`define LBF_STS_BUSY 7

// Interrupt bits
`define LBF_IRQ_TX_DONE 0
`define LBF_IRQ_RX_DONE 1
`define LBF_IRQ_RX_ERR 2

// Timing
`define LBF_CLK_PERIOD_NS 25
`define LBF_BIT_TIME_NS 52080
`define LBF_BIT_CYCLES (`LBF_BIT_TIME_NS / `LBF_CLK_PERIOD_NS)
`define LBF_BREAK_BASE_BITS 5'h0d
`define LBF_RX_MIN_BITS 5'h0b

// Bus responses
`define LBF_RESP_OKAY 2'h0
`define LBF_RESP_SLVERR 2'h2

`endif

// ===== logic/lin_break_pkg.sv
// Types shared by the LIN break field controller.
// Assumes lin_break_map.svh is compiled alongside for the constants.
package lin_break_pkg;

   typedef enum logic [0:0] {TX_IDLE, TX_BREAK} tx_state_type;

   typedef enum logic [1:0] {RX_OFF, RX_WAIT, RX_LOW} rx_state_type;

   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
      logic aw_have;
      logic [5:0] aw_idx;
      logic w_have;
      logic [7:0] wbyte;
      logic wlane0;
      logic power;
      logic txe;
      logic rxe;
      logic [2:0] sel;
      logic tx_inv;
      logic rx_inv;
      logic rx_flag;
      tx_state_type tx_st;
      rx_state_type rx_st;
      logic [4:0] tx_bits;
      logic [4:0] rx_bits;
      logic tx_pin;
      logic [2:0] irq_stat;
      logic [2:0] irq_mask;
      logic irq;
   } state_type;

endpackage

// ===== logic/bit_period_counter.sv
// Bit period timer: pulses tick_o once per bit time while run_i is high.
// Restarts from zero whenever run_i drops.
`timescale 1ns/1ps
module bit_period_counter #(
   parameter int unsigned CYCLES = 16
) (
   input wire logic clock_i, // System clock
   input wire logic sys_rst_i, // Asynchronous reset, active high
   input wire logic run_i, // Count while high
   output logic tick_o // One-cycle pulse at end of each bit
);
   logic [11:0] count_q;
   logic [11:0] count_d;

   assign tick_o = run_i && (count_q == 12'(CYCLES - 1));

   always_comb
   begin
      count_d = count_q;
      if (!run_i || tick_o)
         count_d = 12'h000;
      else
         count_d = count_q + 12'h001;
   end

   always_ff @(posedge clock_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
         count_q <= 12'h000;
      else
         count_q <= count_d;
   end
endmodule

// ===== logic/lin_break_field_control.sv
// LIN break field controller: sends and detects sync breaks, holds the
// option register, serves registers over AXI4-Lite.
// Assumes a 40 MHz clock, synchronous serial input, one master.
//
// The AXI4-Lite register port was chosen for this implementation.
`timescale 1ns/1ps
`include "lin_break_map.svh"
module lin_break_field_control
   import lin_break_pkg::*;
(
   input wire logic clock_i, // System clock
   input wire logic sys_rst_i, // Asynchronous reset, active high
   input wire logic [7:0] s_axi_awaddr, // Write address
   input wire logic s_axi_awvalid, // Write address valid
   output logic s_axi_awready, // Write address ready
   input wire logic [31:0] s_axi_wdata, // Write data
   input wire logic [3:0] s_axi_wstrb, // Write byte strobes
   input wire logic s_axi_wvalid, // Write data valid
   output logic s_axi_wready, // Write data ready
   output logic [1:0] s_axi_bresp, // Write response
   output logic s_axi_bvalid, // Write response valid
   input wire logic s_axi_bready, // Write response ready
   input wire logic [7:0] s_axi_araddr, // Read address
   input wire logic s_axi_arvalid, // Read address valid
   output logic s_axi_arready, // Read address ready
   output logic [31:0] s_axi_rdata, // Read data
   output logic [1:0] s_axi_rresp, // Read response
   output logic s_axi_rvalid, // Read data valid
   input wire logic s_axi_rready, // Read data ready
   input wire logic transfer_busy_i, // Data transfer in progress
   input wire logic serial_rx_pin_i, // Serial receive line
   output logic serial_tx_pin_o, // Serial transmit line
   output logic irq_o // Interrupt, level, active high
);
   state_type q;
   state_type d;
   logic tx_tick;
   logic rx_tick;
   logic rx_level;

   // Shared bit timer would couple both directions; each has its own
   bit_period_counter #(.CYCLES(`LBF_BIT_CYCLES)) tx_timer (
      .clock_i(clock_i),
      .sys_rst_i(sys_rst_i),
      .run_i(q.tx_st == TX_BREAK),
      .tick_o(tx_tick)
   );

   bit_period_counter #(.CYCLES(`LBF_BIT_CYCLES)) rx_timer (
      .clock_i(clock_i),
      .sys_rst_i(sys_rst_i),
      .run_i(q.rx_st == RX_LOW),
      .tick_o(rx_tick)
   );

   assign rx_level = serial_rx_pin_i ^ q.rx_inv;

   always_comb
   begin
      logic do_write;
      logic wr_opt;
      logic tx_trig;
      logic rx_trig;
      logic rx_on;
      logic rd_take;
      logic [5:0] rd_idx;
      logic [7:0] rd_byte;
      logic rd_ok;
      logic [2:0] len_off;
      logic [4:0] tx_len;
      logic [2:0] events;
      do_write = 1'b0;
      wr_opt = 1'b0;
      tx_trig = 1'b0;
      rx_trig = 1'b0;
      rx_on = 1'b0;
      rd_take = 1'b0;
      rd_idx = 6'h00;
      rd_byte = 8'h00;
      rd_ok = 1'b0;
      len_off = 3'h0;
      tx_len = 5'h00;
      events = 3'h0;
      d = q;

      // Write address and data are taken in either order
      if (s_axi_awvalid && q.awready)
      begin
         d.aw_have = 1'b1;
         d.aw_idx = s_axi_awaddr[7:2];
      end
      if (s_axi_wvalid && q.wready)
      begin
         d.w_have = 1'b1;
         d.wbyte = s_axi_wdata[7:0];
         d.wlane0 = s_axi_wstrb[0];
      end
      if (q.bvalid && s_axi_bready)
         d.bvalid = 1'b0;

      if (q.aw_have && q.w_have && !q.bvalid)
      begin
         do_write = q.wlane0;
         d.aw_have = 1'b0;
         d.w_have = 1'b0;
         d.bvalid = 1'b1;
         d.bresp = `LBF_RESP_OKAY;
         case (q.aw_idx)
            `LBF_IDX_CONTROL, `LBF_IDX_OPTION, `LBF_IDX_STATUS,
            `LBF_IDX_IRQ_STATUS, `LBF_IDX_IRQ_MASK: d.bresp = `LBF_RESP_OKAY;
            default: d.bresp = `LBF_RESP_SLVERR;
         endcase
      end
      d.awready = !d.aw_have;
      d.wready = !d.w_have;

      if (do_write && q.aw_idx == `LBF_IDX_CONTROL)
      begin
         d.power = q.wbyte[`LBF_CTL_POWER];
         d.txe = q.wbyte[`LBF_CTL_TXE];
         d.rxe = q.wbyte[`LBF_CTL_RXE];
      end
      wr_opt = do_write && q.aw_idx == `LBF_IDX_OPTION;
      if (wr_opt)
      begin
         d.sel = q.wbyte[`LBF_OPT_SEL_HI:`LBF_OPT_SEL_LO];
         d.tx_inv = q.wbyte[`LBF_OPT_TX_INV];
         d.rx_inv = q.wbyte[`LBF_OPT_RX_INV];
      end
      if (do_write && q.aw_idx == `LBF_IDX_IRQ_MASK)
         d.irq_mask = q.wbyte[2:0];

      // Triggers act only in the write cycle and are never stored
      tx_trig = wr_opt && q.wbyte[`LBF_OPT_TX_TRIG];
      rx_trig = wr_opt && q.wbyte[`LBF_OPT_RX_TRIG];

      // Break transmission
      len_off = q.sel + 3'h3;
      tx_len = `LBF_BREAK_BASE_BITS + {2'b00, len_off};
      case (q.tx_st)
         TX_IDLE:
         begin
            d.tx_pin = 1'b1;
            // Ignored unless transmitter powered and enabled
            if (tx_trig && q.power && q.txe)
            begin
               d.tx_st = TX_BREAK;
               d.tx_bits = 5'h00;
               d.tx_pin = 1'b0;
            end
         end
         TX_BREAK:
         begin
            d.tx_pin = 1'b0;
            if (!(q.power && q.txe))
            begin
               d.tx_st = TX_IDLE;
               d.tx_pin = 1'b1;
            end
            else if (tx_tick)
            begin
               d.tx_bits = q.tx_bits + 5'h01;
               if (q.tx_bits + 5'h01 == tx_len)
               begin
                  d.tx_st = TX_IDLE;
                  d.tx_pin = 1'b1;
                  events[`LBF_IRQ_TX_DONE] = 1'b1;
               end
            end
         end
         default:
            d.tx_st = TX_IDLE;
      endcase
      d.tx_pin = d.tx_pin ^ d.tx_inv;
      // Break reception
      rx_on = q.power && q.rxe;
      case (q.rx_st)
         RX_OFF:
         begin
            if (rx_trig && rx_on)
            begin
               d.rx_st = RX_WAIT;
               d.rx_flag = 1'b1;
            end
         end
         RX_WAIT:
         begin
            d.rx_bits = 5'h00;
            if (!rx_on)
               d.rx_st = RX_OFF;
            else if (!rx_level)
               d.rx_st = RX_LOW;
         end
         RX_LOW:
         begin
            if (!rx_on)
               d.rx_st = RX_OFF;
            else if (rx_level)
            begin
               if (q.rx_bits >= `LBF_RX_MIN_BITS)
               begin
                  d.rx_st = RX_OFF;
                  d.rx_flag = 1'b0;
                  events[`LBF_IRQ_RX_DONE] = 1'b1;
               end
               else
               begin
                  // Too short: flag stays set, detection re-arms
                  d.rx_st = RX_WAIT;
                  events[`LBF_IRQ_RX_ERR] = 1'b1;
               end
            end
            else if (rx_tick && q.rx_bits != 5'h1f)
               d.rx_bits = q.rx_bits + 5'h01;
         end
         default:
            d.rx_st = RX_OFF;
      endcase
      if (!q.power && !q.rxe)
         d.rx_flag = 1'b0;

      // Register reads
      rd_take = s_axi_arvalid && q.arready;
      rd_idx = s_axi_araddr[7:2];
      rd_ok = 1'b1;
      case (rd_idx)
         `LBF_IDX_CONTROL:
            rd_byte = {q.power, q.txe, q.rxe, 5'h00};
         `LBF_IDX_OPTION:
            rd_byte = {q.rx_flag, 2'b00, q.sel, q.tx_inv, q.rx_inv};
         `LBF_IDX_STATUS:
            rd_byte = {transfer_busy_i, 7'h00};
         `LBF_IDX_IRQ_STATUS:
            rd_byte = {5'h00, q.irq_stat};
         `LBF_IDX_IRQ_MASK:
            rd_byte = {5'h00, q.irq_mask};
         default:
         begin
            rd_byte = 8'h00;
            rd_ok = 1'b0;
         end
      endcase
      if (rd_take)
      begin
         d.arready = 1'b0;
         d.rvalid = 1'b1;
         d.rdata = {24'h000000, rd_byte};
         d.rresp = rd_ok ? `LBF_RESP_OKAY : `LBF_RESP_SLVERR;
      end
      if (q.rvalid && s_axi_rready)
      begin
         d.rvalid = 1'b0;
         d.arready = 1'b1;
      end

      // A read clears status; an event in the same cycle still lands
      if (rd_take && rd_idx == `LBF_IDX_IRQ_STATUS)
         d.irq_stat = events;
      else
         d.irq_stat = q.irq_stat | events;
      d.irq = |(d.irq_stat & d.irq_mask);
   end

   always_ff @(posedge clock_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         q <= '0;
         q.awready <= 1'b1;
         q.wready <= 1'b1;
         q.arready <= 1'b1;
         q.sel <= 3'h5;
         q.tx_pin <= 1'b1;
         q.tx_st <= TX_IDLE;
         q.rx_st <= RX_OFF;
      end
      else
         q <= d;
   end

   assign s_axi_awready = q.awready;
   assign s_axi_wready = q.wready;
   assign s_axi_bvalid = q.bvalid;
   assign s_axi_bresp = q.bresp;
   assign s_axi_arready = q.arready;
   assign s_axi_rvalid = q.rvalid;
   assign s_axi_rresp = q.rresp;
   assign s_axi_rdata = q.rdata;
   assign serial_tx_pin_o = q.tx_pin;
   assign irq_o = q.irq;
endmodule

// ===== sim/lin_break_props.sv
// Port checker for the LIN break controller.
// Bound to every lin_break_field_control instance below.
`timescale 1ns/1ps
`include "lin_break_map.svh"
module lin_break_props (
   input wire logic clock_i, // Clock
   input wire logic sys_rst_i, // Reset
   input wire logic s_axi_awvalid, // AW valid
   input wire logic s_axi_awready, // AW ready
   input wire logic s_axi_wvalid, // W valid
   input wire logic s_axi_wready, // W ready
   input wire logic [1:0] s_axi_bresp, // B resp
   input wire logic s_axi_bvalid, // B valid
   input wire logic s_axi_bready, // B ready
   input wire logic s_axi_arvalid, // AR valid
   input wire logic s_axi_arready, // AR ready
   input wire logic [31:0] s_axi_rdata, // R data
   input wire logic s_axi_rvalid, // R valid
   input wire logic s_axi_rready, // R ready
   input wire logic serial_tx_pin_o // Tx line
);
   localparam int TX_MAX = 20 * `LBF_BIT_CYCLES + 1;
   logic [16:0] low_q;
   // Counts how long the line has been low, to bound a break
   always_ff @(posedge clock_i or posedge sys_rst_i)
      if (sys_rst_i)
         low_q <= '0;
      else
         low_q <= serial_tx_pin_o ? '0 : low_q + 1'b1;
   default clocking @(posedge clock_i); endclocking
   default disable iff (sys_rst_i);
   property p_ar_answer;
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
   endproperty
   a_ar_answer: assert property (p_ar_answer)
      else $error("read not answered");
   property p_r_hold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   a_r_hold: assert property (p_r_hold)
      else $error("read data dropped");
   property p_r_clear;
      s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready;
   endproperty
   a_r_clear: assert property (p_r_clear)
      else $error("read not retired");
   property p_b_hold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   a_b_hold: assert property (p_b_hold)
      else $error("write response dropped");
   property p_b_two;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
         |=> !s_axi_bvalid ##1 s_axi_bvalid;
   endproperty
   a_b_two: assert property (p_b_two)
      else $error("write response late");
   property p_r_byte;
      s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0;
   endproperty
   a_r_byte: assert property (p_r_byte)
      else $error("upper read bits set");
   property p_resp;
      s_axi_bvalid |-> s_axi_bresp inside {2'h0, 2'h2};
   endproperty
   a_resp: assert property (p_resp)
      else $error("bad write response");
   property p_tx_max;
      low_q <= TX_MAX;
   endproperty
   a_tx_max: assert property (p_tx_max)
      else $error("break too long");
   c_write: cover property (s_axi_bvalid && s_axi_bready);
   c_read: cover property (s_axi_rvalid && s_axi_rready);
   c_break: cover property ($fell(serial_tx_pin_o));
endmodule
bind lin_break_field_control lin_break_props u_props (.clock_i, .sys_rst_i,
   .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
   .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
   .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
   .serial_tx_pin_o);

// ===== sim/lin_node.sv
// LIN node model on the far side of the serial lines.
// Line idles recessive high; the bench calls drive_low for a break.
`timescale 1ns/1ps
module lin_node (
   input wire logic clock_i, // Clock
   input wire logic tx_line_i, // Line from the block
   output logic rx_line_o // Line into the block
);
   int low_len = 0;
   int cnt = 0;
   initial rx_line_o = 1'b1;
   // Length of the last dominant period seen on the transmit line
   always @(posedge clock_i)
   begin
      if (!tx_line_i)
         cnt <= cnt + 1;
      else if (cnt != 0)
      begin
         low_len <= cnt;
         cnt <= 0;
      end
   end
   task drive_low(input int n);
      rx_line_o <= 1'b0;
      repeat (n) @(posedge clock_i);
      rx_line_o <= 1'b1;
   endtask
endmodule

// ===== sim/tb.sv
// Self-checking bench for the LIN break controller.
// Needs the design, lin_node and the checker compiled first.
`timescale 1ns/1ps
`include "lin_break_map.svh"
module tb;
   localparam int B = `LBF_BIT_CYCLES;
   logic clock_i, sys_rst_i, awv, wv, bry, arv, rry, busy, rxl;
   logic [3:0] ws;
   logic awr, wrd, bv, arr, rv, txp, irq;
   logic [7:0] awa, ara;
   logic [1:0] br, rr;
   logic [31:0] wd, rdt;
   int errors, compares;
   lin_node node (.clock_i, .tx_line_i(txp), .rx_line_o(rxl));
   lin_break_field_control dut (.clock_i, .sys_rst_i, .s_axi_awaddr(awa),
      .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
      .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wrd),
      .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bry),
      .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
      .s_axi_rdata(rdt), .s_axi_rresp(rr), .s_axi_rvalid(rv),
      .s_axi_rready(rry), .transfer_busy_i(busy),
      .serial_rx_pin_i(rxl), .serial_tx_pin_o(txp), .irq_o(irq));
   task complete_run;
      $display("errors %0d compares %0d", errors, compares);
      if (errors == 0 && compares > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task chk(input string n, input logic [31:0] e, g);
      compares++;
      if (g !== e)
      begin
         errors++;
         $display("[ERR] %s exp %h got %h", n, e, g);
      end
   endtask
   task wr(input logic [7:0] a, d, input logic [1:0] er = 2'h0);
      int n;
      awa <= a;
      wd <= {24'h0, d};
      awv <= 1'b1;
      wv <= 1'b1;
      bry <= 1'b1;
      n = 0;
      do
      begin
         @(posedge clock_i);
         // Drop each valid after its handshake, so the same write is not taken twice
         if (awv && awr)
            awv <= 1'b0;
         if (wv && wrd)
            wv <= 1'b0;
         n++;
      end
      while (bv !== 1'b1 && n < 100);
      if (bv !== 1'b1)
      begin
         errors++;
         complete_run();
      end
      else
         chk("bresp", er, br);
   endtask
   task rdc(input string s, input logic [7:0] a, input logic [31:0] e,
      input logic [1:0] er = 2'h0);
      int n;
      ara <= a;
      arv <= 1'b1;
      rry <= 1'b1;
      n = 0;
      do
      begin
         @(posedge clock_i);
         if (arv && arr)
            arv <= 1'b0;
         n++;
      end
      while (rv !== 1'b1 && n < 100);
      if (rv !== 1'b1)
      begin
         errors++;
         complete_run();
      end
      else
      begin
         chk(s, e, rdt);
         chk("rresp", er, rr);
      end
   endtask
   task s_reset;
      rdc("option", 8'h0c, 32'h14);
      rdc("control", 8'h00, 32'h0);
      rdc("unmapped", 8'h40, 32'h0, 2'h2);
      wr(8'h40, 8'hff, 2'h2);
   endtask
   task s_fields;
      // Triggers written with power off must not start anything
      for (int i = 0; i < 8; i++)
      begin
         // Transmit inversion stays off so the line never looks broken
         wr(8'h0c, {3'b011, i[2:0], 2'b01});
         rdc("sel", 8'h0c, {27'h0, i[2:0], 2'b01});
      end
      wr(8'h0c, 8'h14);
      ws <= 4'h0;
      wr(8'h0c, 8'h17);
      ws <= 4'h1;
      rdc("strobe", 8'h0c, 32'h14);
      busy <= 1'b1;
      rdc("status", 8'h10, 32'h80);
      busy <= 1'b0;
   endtask
   task tx_break(input logic [2:0] s, input int bits);
      int n, d, prev;
      prev = node.low_len;
      wr(8'h00, 8'h00);
      wr(8'h0c, {3'b000, s, 2'b00});
      wr(8'h00, 8'hc0);
      rdc("busy", 8'h10, 32'h0);
      wr(8'h0c, {3'b001, s, 2'b00});
      n = 0;
      while (node.low_len == prev && n < 45000)
      begin
         @(posedge clock_i);
         n++;
      end
      d = node.low_len - bits * B;
      chk("tx_len", 1, d >= -1 && d <= 1);
      repeat (3) @(posedge clock_i);
      chk("irq", 1, irq);
      rdc("irq_stat", 8'h14, 32'h1);
      repeat (2) @(posedge clock_i);
      chk("irq", 0, irq);
   endtask
   task s_tx;
      wr(8'h18, 8'h07);
      // Two codes on either side of the wrap tell the mapping apart
      tx_break(3'h5, 13);
      tx_break(3'h0, 16);
      wr(8'h00, 8'h00);
      wr(8'h0c, 8'h16);
      repeat (3) @(posedge clock_i);
      chk("tx_inv", 0, txp);
      wr(8'h0c, 8'h14);
      repeat (3) @(posedge clock_i);
      chk("tx_norm", 1, txp);
   endtask
   task s_rx;
      wr(8'h00, 8'h80);
      wr(8'h0c, 8'h54);
      rdc("no_rxe", 8'h0c, 32'h14);
      wr(8'h00, 8'ha0);
      wr(8'h0c, 8'h54);
      rdc("armed", 8'h0c, 32'h94);
      node.drive_low(2 * B);
      repeat (4) @(posedge clock_i);
      rdc("rx_err", 8'h14, 32'h4);
      // Flipping the input sense while armed looks like a short break
      wr(8'h0c, 8'h15);
      wr(8'h0c, 8'h14);
      rdc("rx_inv", 8'h14, 32'h4);
      rdc("kept", 8'h0c, 32'h94);
      wr(8'h00, 8'h00);
      rdc("cleared", 8'h0c, 32'h14);
      wr(8'h00, 8'ha0);
      wr(8'h0c, 8'h54);
      node.drive_low(12 * B);
      repeat (4) @(posedge clock_i);
      rdc("rx_done", 8'h14, 32'h2);
      rdc("flag", 8'h0c, 32'h14);
   endtask
   initial
   begin
      clock_i = 1'b0;
      forever #12.5 clock_i = ~clock_i;
   end
   initial
   begin
      sys_rst_i = 1'b1;
      {awv, wv, bry, arv, rry, busy} = '0;
      {awa, ara, wd} = '0;
      ws = 4'h1;
      repeat (5) @(posedge clock_i);
      sys_rst_i <= 1'b0;
      @(posedge clock_i);
      s_reset();
      s_fields();
      s_tx();
      s_rx();
      complete_run();
   end
endmodule
